// file: rtl/bgc_fetch_if.sv
`default_nettype none

interface bgc_fetch_if;
    logic limit;
    logic quad_req;
    logic line_check_en;
    logic fetch_single;
    logic fetch_line;
    logic quad_eff;

    modport regs (
        output limit,
        output quad_req,
        output line_check_en,
        input  fetch_single,
        input  fetch_line,
        input  quad_eff
    );

    modport policy (
        input  limit,
        input  quad_req,
        input  line_check_en,
        output fetch_single,
        output fetch_line,
        output quad_eff
    );
endinterface : bgc_fetch_if

`default_nettype wire

// file: rtl/bgc_fetch_policy.sv
`default_nettype none

module bgc_fetch_policy
    import bgc_pkg::*;
(
    // clock and reset
    input wire logic     clk_sys,
    input wire logic     srst,
    // fetch control
    bgc_fetch_if.policy  fi
);

    logic limit_active;

    // the limit bit only counts while cache line checking is on
    assign limit_active = fi.line_check_en & fi.limit;

    // registered so the read engine sees a clean level per cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fi.fetch_single <= 1'b0;
            fi.fetch_line   <= 1'b1;
            fi.quad_eff     <= 1'b0;
        end else begin
            fi.fetch_single <= limit_active;
            fi.fetch_line   <= ~limit_active;
            fi.quad_eff     <= fi.quad_req & ~limit_active;
        end
    end

endmodule : bgc_fetch_policy

`default_nettype wire

// file: rtl/bgc_gen_ctrl.sv
`default_nettype none

module bgc_gen_ctrl
    import bgc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // reset pins, asynchronous to clk_sys
    input  wire logic        pcie_reset_n,
    input  wire logic        global_reset_n,
    // configuration access to the general control word
    input  wire logic        cfg_wr_en,
    input  wire logic [3:0]  cfg_wr_be,
    input  wire logic [31:0] cfg_wr_data,
    output logic      [31:0] cfg_rd_data,
    // transaction layer control bits
    input  wire logic        cache_line_check_en,
    input  wire logic        quad_fetch_enable,
    // reset and capability outputs
    output logic             fundamental_reset_n,
    output logic      [2:0]  cap_standby_exit_latency,
    output logic      [2:0]  cap_lowpower_exit_latency,
    output logic      [11:0] aer_next_offset,
    // power response outputs
    output logic             power_exceeded_output,
    output logic             secondary_clk_stop,
    output logic             unsupported_req_all,
    // burst read fetch policy
    output logic             burst_fetch_single_dword,
    output logic             burst_fetch_to_line,
    output logic             quad_fetch_active
);

    // decode of a power response code into {ur_all, clk_stop, assert_out}
    function automatic logic [2:0] pwr_decode(input bgc_pwr_resp_t code);
        logic [2:0] r;
        r = 3'h0;
        case (code)
            PWR_ASSERT:   r = 3'b001;
            PWR_CLK_STOP: r = 3'b010;
            PWR_BOTH:     r = 3'b011;
            PWR_UR_ALL:   r = 3'b100;
            default:      r = 3'h0; // ignore and reserved codes do nothing
        endcase
        return r;
    endfunction : pwr_decode

    logic [SYNC_STAGES-1:0] pcie_sync_q;
    logic [SYNC_STAGES-1:0] glb_sync_q;
    logic                   pcie_filt_q;
    logic                   glb_filt_q;
    logic                   fundamental_reset_n_n_q;
    bgc_pwr_resp_t          pwr_resp_q;
    logic                   fetch_limit_q;
    logic [2:0]             stby_lat_q;
    logic [2:0]             lpwr_lat_q;
    logic [2:0]             pwr_act_q;
    logic                   field_rst;
    logic [2:0]             wr_stby;
    logic [2:0]             wr_lpwr;
    logic                   wr_hi;
    logic                   wr_lo;

    bgc_fetch_if fetch_bus ();

    // reset pins through three flops; sampled low during srst
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pcie_sync_q <= '0;
            glb_sync_q  <= '0;
        end else begin
            pcie_sync_q <= {pcie_sync_q[SYNC_STAGES-2:0], pcie_reset_n};
            glb_sync_q  <= {glb_sync_q[SYNC_STAGES-2:0], global_reset_n};
        end
    end

    // a level counts only when the last two stages agree
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pcie_filt_q <= 1'b0;
            glb_filt_q  <= 1'b0;
        end else begin
            if (pcie_sync_q[1] == pcie_sync_q[2]) begin
                pcie_filt_q <= pcie_sync_q[2];
            end
            if (glb_sync_q[1] == glb_sync_q[2]) begin
                glb_filt_q <= glb_sync_q[2];
            end
        end
    end

    // fundamental reset low while either pin is low
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fundamental_reset_n_n_q <= 1'b0;
        end else begin
            fundamental_reset_n_n_q <= pcie_filt_q & glb_filt_q;
        end
    end

    // power-on srst also counts as a fundamental reset
    assign field_rst = srst | ~fundamental_reset_n_n_q;
    assign wr_hi     = cfg_wr_en & cfg_wr_be[GC_BYTE_HI];
    assign wr_lo     = cfg_wr_en & cfg_wr_be[GC_BYTE_LO];
    assign wr_stby   = cfg_wr_data[GC_STBY_MSB:GC_STBY_LSB];
    assign wr_lpwr   = cfg_wr_data[GC_LPWR_MSB:GC_LPWR_LSB];

    // power response select never takes write data; slot power limit unsupported
    always_ff @(posedge clk_sys) begin
        if (field_rst) begin
            pwr_resp_q <= PWR_IGNORE;
        end else begin
            pwr_resp_q <= PWR_IGNORE;
        end
    end

    // writable fields, cleared only by the fundamental reset
    always_ff @(posedge clk_sys) begin
        if (field_rst) begin
            fetch_limit_q <= FETCH_RST;
            stby_lat_q    <= STBY_RST;
        end else if (wr_hi) begin
            fetch_limit_q <= cfg_wr_data[GC_FETCH_BIT];
            stby_lat_q    <= wr_stby;
        end
    end

    // bit 12 of this lane is read-only, so only the latency bits load
    always_ff @(posedge clk_sys) begin
        if (field_rst) begin
            lpwr_lat_q <= LPWR_RST;
        end else if (wr_lo) begin
            lpwr_lat_q <= wr_lpwr;
        end
    end

    // power response actions, all quiet while the code is fixed at ignore
    always_ff @(posedge clk_sys) begin
        if (field_rst) begin
            pwr_act_q <= 3'h0;
        end else begin
            pwr_act_q <= pwr_decode(pwr_resp_q);
        end
    end

    assign power_exceeded_output = pwr_act_q[0];
    assign secondary_clk_stop    = pwr_act_q[1];
    assign unsupported_req_all   = pwr_act_q[2];

    // mirrors into the device capabilities word
    assign cap_standby_exit_latency  = stby_lat_q;
    assign cap_lowpower_exit_latency = lpwr_lat_q;

    // capability enable is constant 0, so the chain ends at the error capability
    assign aer_next_offset = VCAP_VAL ? NEXT_OFF_VC : NEXT_OFF_NONE;

    // read view: only bits 22:12 belong here, others read zero
    always_comb begin
        cfg_rd_data                            = 32'h0000_0000;
        cfg_rd_data[GC_PWR_MSB:GC_PWR_LSB]     = pwr_resp_q;
        cfg_rd_data[GC_FETCH_BIT]              = fetch_limit_q;
        cfg_rd_data[GC_STBY_MSB:GC_STBY_LSB]   = stby_lat_q;
        cfg_rd_data[GC_LPWR_MSB:GC_LPWR_LSB]   = lpwr_lat_q;
        cfg_rd_data[GC_VCAP_BIT]               = VCAP_VAL;
    end

    assign fundamental_reset_n     = fundamental_reset_n_n_q;
    assign fetch_bus.limit         = fetch_limit_q;
    assign fetch_bus.quad_req      = quad_fetch_enable;
    assign fetch_bus.line_check_en = cache_line_check_en;

    // fetch decode kept apart so the read engine owner can reuse it
    bgc_fetch_policy u_fetch (
        .clk_sys (clk_sys),
        .srst    (srst),
        .fi      (fetch_bus.policy)
    );

    assign burst_fetch_single_dword = fetch_bus.fetch_single;
    assign burst_fetch_to_line      = fetch_bus.fetch_line;
    assign quad_fetch_active        = fetch_bus.quad_eff;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    chk_pwr_fixed: assert property (
        cfg_rd_data[GC_PWR_MSB:GC_PWR_LSB] == 3'h0
    ) else $error("power response field not 000b");

    chk_pwr_write_kept: assert property (
        wr_hi && (cfg_wr_data[GC_PWR_MSB:GC_PWR_LSB] != 3'h0)
        |=> (pwr_resp_q == PWR_IGNORE) && (cfg_rd_data[GC_VCAP_BIT] == 1'b0)
    ) else $error("write changed a fixed field");

    chk_pwr_outputs: assert property (
        ##1 !power_exceeded_output && !secondary_clk_stop && !unsupported_req_all
    ) else $error("power response action while code is ignore");

    chk_fundamental_reset_n_follow: assert property (
        (!pcie_reset_n || !global_reset_n) [*5] |=> !fundamental_reset_n
    ) else $error("fundamental reset not asserted after pin low");

    chk_fundamental_reset_n_release: assert property (
        (pcie_reset_n && global_reset_n) [*6] |=> fundamental_reset_n
    ) else $error("fundamental reset stuck while pins high");

    chk_field_defaults: assert property (
        !fundamental_reset_n |=> (stby_lat_q == STBY_RST) && (lpwr_lat_q == LPWR_RST)
                                 && (fetch_limit_q == FETCH_RST)
    ) else $error("fields not cleared by fundamental reset");

    chk_field_hold: assert property (
        fundamental_reset_n && !cfg_wr_en |=> $stable(cfg_rd_data)
    ) else $error("field changed without write or fundamental reset");

    chk_stby_mirror: assert property (
        wr_hi && fundamental_reset_n
        |=> cap_standby_exit_latency == $past(wr_stby)
    ) else $error("standby latency not mirrored");

    chk_lpwr_mirror: assert property (
        wr_lo && fundamental_reset_n
        |=> cap_lowpower_exit_latency == $past(wr_lpwr)
    ) else $error("low-power latency not mirrored");

    chk_vc_offset: assert property (
        aer_next_offset == NEXT_OFF_NONE
    ) else $error("next offset not 000h");

    chk_fetch_single: assert property (
        cache_line_check_en && fetch_limit_q
        |=> burst_fetch_single_dword && !burst_fetch_to_line && !quad_fetch_active
    ) else $error("limit set but fetch not single dword");

    chk_fetch_ignored: assert property (
        !cache_line_check_en |=> burst_fetch_to_line && !burst_fetch_single_dword
    ) else $error("limit acted without line check");

    chk_quad_pass: assert property (
        (!cache_line_check_en || !fetch_limit_q) && quad_fetch_enable |=> quad_fetch_active
    ) else $error("quad fetch lost while limit inactive");

    cov_stby_write: cover property (wr_hi ##1 cap_standby_exit_latency == 3'h7);
    cov_fundamental_reset_n_pulse: cover property (fundamental_reset_n ##1 !fundamental_reset_n);
    cov_single:     cover property (burst_fetch_single_dword);
    cov_quad:       cover property (quad_fetch_active);

endmodule : bgc_gen_ctrl

`default_nettype wire

// file: rtl/bgc_pkg.sv
// Summary of operation
// - Power response select, bits 22:20, is hardwired to 000b (slot power limit ignored).
// - Codes 001 power out, 010 clock stop, 011 both, 100 UR except config, 101-111 reserved.
// - Fields of bits 22:12 return to default only on the fundamental reset, never on others.
// - The active-low fundamental reset is asserted while the PCIe or global reset pin is low.
// - Burst read fetch limit bit 19 at 0 (default) fetches to line end, at 1 one doubleword.
// - While the fetch limit bit and cache line check enable are both set the quad fetch enable has no effect on reads.
// - The fetch limit bit acts only while cache line check enable is set, else it is ignored.
// - Standby exit latency, bits 18:16, drives device capabilities bits 8:6 at offset 94h.
// - Standby latency codes: 000 below 64 ns (default), doubling per code, up to 111.
// - Low-power exit latency, bits 15:13, drives device capabilities bits 11:9 at offset 94h.
// - Low-power latency codes: 000 below 1 us (default), doubling per code, 111 above 64 us.
// - Capability enable bit 12 reads constant 0, so the next offset at 102h reads 000h.
// - Its enabled encoding would link the next offset to 150h, which never happens.
`default_nettype none

package bgc_pkg;

    // field positions inside the general control word
    localparam int GC_PWR_MSB     = 22;
    localparam int GC_PWR_LSB     = 20;
    localparam int GC_FETCH_BIT   = 19;
    localparam int GC_STBY_MSB    = 18;
    localparam int GC_STBY_LSB    = 16;
    localparam int GC_LPWR_MSB    = 15;
    localparam int GC_LPWR_LSB    = 13;
    localparam int GC_VCAP_BIT    = 12;

    // byte lanes that carry the writable fields
    localparam int GC_BYTE_HI     = 2;
    localparam int GC_BYTE_LO     = 1;

    // reset and fixed values
    localparam logic [2:0] STBY_RST  = 3'h0;
    localparam logic [2:0] LPWR_RST  = 3'h0;
    localparam logic       FETCH_RST = 1'b0;
    localparam logic       VCAP_VAL  = 1'b0;

    // mirrored destinations
    localparam logic [11:0] DEVCAP_OFFSET   = 12'h094;
    localparam int          DEVCAP_STBY_LSB = 6;
    localparam int          DEVCAP_LPWR_LSB = 9;
    localparam logic [11:0] AER_CAP_OFFSET  = 12'h102;
    localparam logic [11:0] NEXT_OFF_NONE   = 12'h000;
    localparam logic [11:0] NEXT_OFF_VC     = 12'h150;

    // latency bin floors: standby in ns, low-power in us
    localparam int STBY_BIN0_NS = 64;
    localparam int LPWR_BIN0_US = 1;
    localparam int LPWR_TOP_US  = 64;

    // reset pin filter depth
    localparam int SYNC_STAGES = 3;

    typedef enum logic [2:0] {
        PWR_IGNORE   = 3'b000,
        PWR_ASSERT   = 3'b001,
        PWR_CLK_STOP = 3'b010,
        PWR_BOTH     = 3'b011,
        PWR_UR_ALL   = 3'b100
    } bgc_pwr_resp_t;

endpackage : bgc_pkg

`default_nettype wire

// file: verif/bgc_gen_ctrl_tb.sv
`default_nettype none

module bgc_gen_ctrl_tb
    import bgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, resets and stimulus
    logic        clk_sys        = 1'b0;
    logic        srst           = 1'b1;
    logic        pcie_reset_n   = 1'b1;
    logic        global_reset_n = 1'b1;
    logic        cfg_wr_en      = 1'b0;
    logic [3:0]  cfg_wr_be      = 4'h0;
    logic [31:0] cfg_wr_data    = 32'h0000_0000;
    logic        line_chk       = 1'b0;
    logic        quad_en        = 1'b0;
    // observed outputs
    logic [31:0] cfg_rd_data;
    logic        fundamental_reset_n_n;
    logic [2:0]  cap_stby;
    logic [2:0]  cap_lpwr;
    logic [11:0] aer_next;
    logic        pwr_out;
    logic        clk_stop;
    logic        ur_all;
    logic        f_single;
    logic        f_line;
    logic        f_quad;
    int          n_mismatch     = 0;
    int          n_compared     = 0;

    // 50 ns period
    always #25 clk_sys = ~clk_sys;

    bgc_gen_ctrl u_bgc_gen_ctrl (
        .clk_sys                   (clk_sys),
        .srst                      (srst),
        .pcie_reset_n              (pcie_reset_n),
        .global_reset_n            (global_reset_n),
        .cfg_wr_en                 (cfg_wr_en),
        .cfg_wr_be                 (cfg_wr_be),
        .cfg_wr_data               (cfg_wr_data),
        .cfg_rd_data               (cfg_rd_data),
        .cache_line_check_en       (line_chk),
        .quad_fetch_enable         (quad_en),
        .fundamental_reset_n       (fundamental_reset_n_n),
        .cap_standby_exit_latency  (cap_stby),
        .cap_lowpower_exit_latency (cap_lpwr),
        .aer_next_offset           (aer_next),
        .power_exceeded_output     (pwr_out),
        .secondary_clk_stop        (clk_stop),
        .unsupported_req_all       (ur_all),
        .burst_fetch_single_dword  (f_single),
        .burst_fetch_to_line       (f_line),
        .quad_fetch_active         (f_quad)
    );

    // one comparison of any result, zero-extended to a word
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one-cycle write strobe, launched and dropped on falling edges
    task automatic wr(input logic [3:0] be, input logic [31:0] data);
        @(negedge clk_sys);
        cfg_wr_en   = 1'b1;
        cfg_wr_be   = be;
        cfg_wr_data = data;
        @(negedge clk_sys);
        cfg_wr_en   = 1'b0;
    endtask : wr

    // bounded wait for the fundamental reset to reach a level
    task automatic wait_fundamental_reset_n(input logic lvl);
        int k;
        for (k = 0; k < 20 && fundamental_reset_n_n !== lvl; k++) @(negedge clk_sys);
        check("fundamental_reset_n", {31'h0, lvl}, {31'h0, fundamental_reset_n_n});
    endtask : wait_fundamental_reset_n

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #(50 * 4000);
        n_mismatch++;
        summarize();
    end

    // main sequence
    initial begin
        int         i;
        logic       lim;
        logic [2:0] fexp;
        repeat (6) @(negedge clk_sys);
        check("fundamental_reset_n_in_srst", 32'h0, {31'h0, fundamental_reset_n_n});
        srst = 1'b0;
        @(negedge clk_sys);
        check("rd_after_reset", 32'h0, cfg_rd_data);
        check("fetch_after_reset", 32'h2, {29'h0, f_single, f_line, f_quad});
        wait_fundamental_reset_n(1'b1);
        // every writable bit set, fixed bits must stay 0
        wr(4'hF, 32'hFFFF_FFFF);
        check("rd_all_ones", 32'h000F_E000, cfg_rd_data);
        check("aer_next", {20'h0, NEXT_OFF_NONE}, {20'h0, aer_next});
        // every power response code is refused by the hardwired field
        for (i = 1; i < 8; i++) begin
            wr(4'h4, 32'(i) << 20);
            check("pwr_field", 32'h0, cfg_rd_data & 32'h0070_0000);
            check("pwr_outputs", 32'h0, {29'h0, pwr_out, clk_stop, ur_all});
        end
        // all latency codes, mirrored into the capability bits
        for (i = 0; i < 8; i++) begin
            wr(4'h6, (32'(i) << 16) | (32'(7 - i) << 13));
            check("rd_lat", (32'(i) << 16) | (32'(7 - i) << 13), cfg_rd_data);
            check("cap_stby", 32'(i), {29'h0, cap_stby});
            check("cap_lpwr", 32'(7 - i), {29'h0, cap_lpwr});
        end
        // byte lanes load independently
        wr(4'h2, 32'hFFFF_FFFF);
        check("rd_lane1", 32'h0007_E000, cfg_rd_data);
        wr(4'h4, 32'h0000_0000);
        check("rd_lane2", 32'h0000_E000, cfg_rd_data);
        wr(4'h9, 32'hFFFF_FFFF);
        check("rd_other_lanes", 32'h0000_E000, cfg_rd_data);
        // fetch policy across line check, limit bit and quad request
        for (i = 0; i < 8; i++) begin
            wr(4'h4, 32'(i & 2) << 18);
            line_chk = i[2];
            quad_en  = i[0];
            repeat (2) @(negedge clk_sys);
            lim  = i[2] & i[1];
            fexp = {lim, ~lim, i[0] & ~lim};
            check("fetch", {29'h0, fexp}, {29'h0, f_single, f_line, f_quad});
        end
        // each reset pin clears the fields and blocks writes meanwhile
        for (i = 0; i < 2; i++) begin
            wr(4'hF, 32'hFFFF_FFFF);
            if (i == 0) pcie_reset_n = 1'b0;
            else global_reset_n = 1'b0;
            wait_fundamental_reset_n(1'b0);
            repeat (2) @(negedge clk_sys);
            wr(4'hF, 32'hFFFF_FFFF);
            check("rd_pin_reset", 32'h0, cfg_rd_data);
            check("caps_pin_reset", 32'h0, {26'h0, cap_stby, cap_lpwr});
            pcie_reset_n   = 1'b1;
            global_reset_n = 1'b1;
            wait_fundamental_reset_n(1'b1);
            check("rd_after_pin", 32'h0, cfg_rd_data);
        end
        summarize();
    end
endmodule : bgc_gen_ctrl_tb

`default_nettype wire
